//--- pkg/gcp_pkg.sv
// Purpose: Shared constants and types for the receiver config packet handler
// Assumes: Big-endian multi-byte fields, bytes counted from the start byte
// Notes:   Body offsets count from the mode byte (packet byte 5)
package gcp_pkg;
    // Framing and identifiers
    localparam logic [7:0]  GCP_DLE        = 8'h10;
    localparam logic [7:0]  GCP_ETX        = 8'h03;
    localparam logic [7:0]  GCP_PKT_ID     = 8'h91;
    localparam logic [7:0]  GCP_SUB_CODE   = 8'h01;
    localparam logic [7:0]  GCP_MODE_QUERY = 8'h00;
    localparam logic [7:0]  GCP_MODE_SET   = 8'h01;
    localparam logic [7:0]  GCP_MODE_RESP  = 8'h02;
    localparam logic [15:0] GCP_LEN_QUERY  = 16'h0002;
    localparam logic [15:0] GCP_LEN_SET    = 16'h001C;
    localparam int          GCP_BODY_BYTES = 28;
    localparam int          GCP_RESP_BYTES = 35;
    // Body offsets of set fields
    localparam int          GCP_OFS_MODE   = 0;
    localparam int          GCP_OFS_BAND   = 1;
    localparam int          GCP_OFS_ELEV   = 5;
    localparam int          GCP_OFS_SIG    = 9;
    localparam int          GCP_OFS_DOP    = 13;
    localparam int          GCP_OFS_DELAY  = 19;
    // Sentinels and fixed answers
    localparam logic [31:0] GCP_BAND_IGNORE = 32'hFFFF_FFFF;
    localparam logic [31:0] GCP_BAND_SUPP   = 32'h00A3_5135;
    localparam logic [7:0]  GCP_BYTE_IGNORE = 8'hFF;
    localparam logic [31:0] GCP_DOP_IGNORE  = 32'hBF80_0000;
    localparam logic [7:0]  GCP_ANTIJAM_ON  = 8'h01;
    localparam logic [7:0]  GCP_FIX_1HZ     = 8'h00;
    localparam logic [7:0]  GCP_RSVD_BYTE   = 8'hFF;
    // Values after reset
    localparam logic [31:0] GCP_BAND_RST    = 32'h00A3_5135;
    localparam logic [31:0] GCP_ELEV_RST    = 32'h0000_0000;
    localparam logic [31:0] GCP_SIG_RST     = 32'h0000_0000;
    localparam logic [31:0] GCP_DOP_RST     = 32'h4120_0000;
    localparam logic [31:0] GCP_DELAY_RST   = 32'h0000_0000;
    localparam logic        GCP_EN_RST      = 1'b1;
    // Register byte offsets
    localparam logic [7:0]  GCP_REG_CTRL    = 8'h00;
    localparam logic [7:0]  GCP_REG_STAT    = 8'h04;
    localparam logic [7:0]  GCP_REG_BAND    = 8'h08;
    localparam logic [7:0]  GCP_REG_ELEV    = 8'h0C;
    localparam logic [7:0]  GCP_REG_SIG     = 8'h10;
    localparam logic [7:0]  GCP_REG_DOP     = 8'h14;
    localparam logic [7:0]  GCP_REG_DELAY   = 8'h18;

    // Settings in effect
    typedef struct packed {
        logic [31:0] band;
        logic [31:0] elev;
        logic [31:0] min_signal_strength_limit;
        logic [31:0] max_dilution_limit;
        logic [31:0] delay;
    } gcp_settings_t;
endpackage

//--- rtl/gcp_resp_tx.sv
// Purpose: Serialises the settings answer packet onto the byte stream
// Assumes: Sink takes a byte when tx_valid_o and tx_ready_i are both high
// Notes:   Settings are snapshotted at start so the answer is coherent
`timescale 1ns/10ps
module gcp_resp_tx (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            resetn_i,
    // Request
    input  wire logic            start_i,
    input  gcp_pkg::gcp_settings_t settings_i,
    output logic                 busy_o,
    // Byte stream out
    output logic [7:0]           tx_data_o,
    output logic                 tx_valid_o,
    input  wire logic            tx_ready_i
);
    import gcp_pkg::*;

    logic          busy_ff;
    logic [5:0]    idx_ff;
    logic [7:0]    data_ff;
    logic [7:0]    cks_ff;
    gcp_settings_t snap_ff;
    logic [7:0]    nxt_cks;
    logic          last;
    logic          step;

    // Byte k of a big-endian word
    function automatic logic [7:0] wbyte(input logic [31:0] w, input logic [5:0] k);
        wbyte = w[8*(3-k[1:0]) +: 8];
    endfunction

    // Answer byte at position i
    function automatic logic [7:0] resp_byte(input logic [5:0] i, input gcp_settings_t s,
                                             input logic [7:0] c);
        logic [7:0] b;
        b = GCP_RSVD_BYTE;
        if (i == 6'd0 || i == 6'd33) b = GCP_DLE;
        else if (i == 6'd1) b = GCP_PKT_ID;
        else if (i == 6'd2) b = GCP_SUB_CODE;
        else if (i == 6'd3) b = GCP_LEN_SET[15:8];
        else if (i == 6'd4) b = GCP_LEN_SET[7:0];
        else if (i == 6'd5) b = GCP_MODE_RESP;
        else if (i < 6'd10) b = wbyte(s.band, i - 6'd6);
        else if (i < 6'd14) b = wbyte(s.elev, i - 6'd10);
        else if (i < 6'd18) b = wbyte(s.min_signal_strength_limit, i - 6'd14);
        else if (i < 6'd22) b = wbyte(s.max_dilution_limit, i - 6'd18);
        else if (i == 6'd22) b = GCP_ANTIJAM_ON;
        else if (i == 6'd23) b = GCP_FIX_1HZ;
        else if (i < 6'd28) b = wbyte(s.delay, i - 6'd24);
        else if (i == 6'd32) b = c;
        else if (i == 6'd34) b = GCP_ETX;
        return b;
    endfunction

    // Running checksum over identifier to last payload byte
    assign step    = busy_ff & tx_ready_i;
    assign last    = idx_ff == 6'(GCP_RESP_BYTES - 1);
    assign nxt_cks = (idx_ff >= 6'd1 && idx_ff <= 6'd31) ? cks_ff ^ data_ff : cks_ff;

    // Sequencer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_ff <= 1'b0;
            idx_ff  <= 6'd0;
            data_ff <= 8'h00;
            cks_ff  <= 8'h00;
            snap_ff <= '0;
        end else if (start_i && !busy_ff) begin
            busy_ff <= 1'b1;
            idx_ff  <= 6'd0;
            data_ff <= GCP_DLE;
            cks_ff  <= 8'h00;
            snap_ff <= settings_i;
        end else if (step) begin
            busy_ff <= !last;
            idx_ff  <= last ? idx_ff : idx_ff + 6'd1;
            cks_ff  <= nxt_cks;
            data_ff <= resp_byte(idx_ff + 6'd1, snap_ff, nxt_cks);
        end
    end

    assign busy_o     = busy_ff;
    assign tx_valid_o = busy_ff;
    assign tx_data_o  = data_ff;

    // Fixed fields of the answer
    resp_mode_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_valid_o && idx_ff == 6'd5 |-> tx_data_o == GCP_MODE_RESP)
        else $error("answer mode byte wrong");
    antijam_on_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_valid_o && idx_ff == 6'd22 |-> tx_data_o == GCP_ANTIJAM_ON)
        else $error("interference suppression not reported on");
    fix_rate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_valid_o && idx_ff == 6'd23 |-> tx_data_o == GCP_FIX_1HZ)
        else $error("fix rate not reported as one per second");
    resp_len_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_valid_o && idx_ff == 6'd4 |-> tx_data_o == GCP_LEN_SET[7:0])
        else $error("answer length byte wrong");
endmodule

//--- rtl/gcp_cfg_handler.sv
// Purpose: Parses receiver config query and set packets, holds settings,
//          answers with the settings in effect, AHB-Lite register view
// Assumes: Byte stream comes from a UART receiver on clk_i
// Notes:   Packets are framed by their length field, no byte unstuffing
// Notes on behaviour
// - Length counts mode, payload and checksum bytes
// - Payload bytes 6-9 are band-enable mask
// - All-ones band mask keeps current bands
// - Bytes 10-13 hold minimum elevation
// - Bytes 14-17 hold minimum signal strength
// - All-ones sentinel byte keeps field unchanged
// - Bytes 18-21 max dilution, minus one ignored
// - Interference suppression always on, byte 22 ignored
// - Only one fix per second, byte 23 ignored
// - Unsupported or reserved band bits have no effect
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module gcp_cfg_handler (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // Byte stream from UART receiver
    input  wire logic [7:0]        rx_data_i,
    input  wire logic              rx_valid_i,
    // Byte stream to UART transmitter
    output logic [7:0]             tx_data_o,
    output logic                   tx_valid_o,
    input  wire logic              tx_ready_i,
    // Settings in effect
    output gcp_pkg::gcp_settings_t settings_o,
    // AHB-Lite slave
    input  wire logic              hsel_i,
    input  wire logic [31:0]       haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [2:0]        hsize_i,
    input  wire logic [31:0]       hwdata_i,
    input  wire logic              hready_i,
    output logic [31:0]            hrdata_o,
    output logic                   hreadyout_o,
    output logic                   hresp_o
);
    import gcp_pkg::*;

    typedef enum {S_IDLE, S_ID, S_SUB, S_LENH, S_LENL, S_BODY, S_DLE, S_ETX} gcp_state_t;

    gcp_state_t    state_ff;
    gcp_state_t    nxt_state;
    logic [7:0]    body_ff [GCP_BODY_BYTES];
    logic [4:0]    cnt_ff;
    logic [15:0]   len_ff;
    logic [7:0]    cks_ff;
    gcp_settings_t settings_ff;
    gcp_settings_t nxt_settings;
    logic          en_ff;
    logic [7:0]    good_cnt_ff;
    logic [7:0]    bad_cnt_ff;
    logic          pend_ff;
    logic          wr_pend_ff;
    logic [7:0]    wr_addr_ff;
    logic [31:0]   rdata_ff;

    logic          take;
    logic [15:0]   len_new;
    logic          len_ok;
    logic [4:0]    last_idx;
    logic          body_last;
    logic          cks_en;
    logic [7:0]    nxt_cks;
    logic          etx_take;
    logic          cks_ok;
    logic          mode_ok;
    logic          good;
    logic          good_set;
    logic          len_rej;
    logic          bad;
    logic          tx_busy;
    logic          tx_start;
    logic [31:0]   band_w;
    logic [31:0]   elev_w;
    logic [31:0]   sig_w;
    logic [31:0]   dop_w;
    logic [31:0]   delay_w;
    logic          band_skip;
    logic          elev_skip;
    logic          sig_skip;
    logic          dop_skip;
    logic          ahb_go;
    logic [7:0]    ahb_ofs;
    logic [31:0]   rd_mux;

    // Byte acceptance and length check
    assign take      = rx_valid_i & en_ff;
    assign len_new   = {len_ff[7:0], rx_data_i};
    assign len_ok    = len_new == GCP_LEN_QUERY || len_new == GCP_LEN_SET;
    assign last_idx  = len_ff[4:0] - 5'd1;
    assign body_last = cnt_ff == last_idx;

    // Frame sequencer
    always_comb begin
        nxt_state = state_ff;
        if (take) begin
            unique case (state_ff)
                S_IDLE: nxt_state = (rx_data_i == GCP_DLE) ? S_ID : S_IDLE;
                S_ID:   nxt_state = (rx_data_i == GCP_PKT_ID) ? S_SUB : S_IDLE;
                S_SUB:  nxt_state = (rx_data_i == GCP_SUB_CODE) ? S_LENH : S_IDLE;
                S_LENH: nxt_state = S_LENL;
                S_LENL: nxt_state = len_ok ? S_BODY : S_IDLE;
                S_BODY: nxt_state = body_last ? S_DLE : S_BODY;
                S_DLE:  nxt_state = (rx_data_i == GCP_DLE) ? S_ETX : S_IDLE;
                S_ETX:  nxt_state = S_IDLE;
            endcase
        end
        if (!en_ff) nxt_state = S_IDLE;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) state_ff <= S_IDLE;
        else state_ff <= nxt_state;
    end

    // Length capture and body index
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            len_ff <= 16'h0000;
            cnt_ff <= 5'd0;
        end else if (take) begin
            if (state_ff == S_LENH) len_ff <= {8'h00, rx_data_i};
            if (state_ff == S_LENL) len_ff <= len_new;
            if (state_ff == S_LENL) cnt_ff <= 5'd0;
            if (state_ff == S_BODY) cnt_ff <= cnt_ff + 5'd1;
        end
    end

    // Body storage, mode byte through checksum
    always_ff @(posedge clk_i) begin
        if (take && state_ff == S_BODY) body_ff[cnt_ff] <= rx_data_i;
    end

    // Running XOR from identifier through last payload byte
    assign cks_en  = take & (state_ff == S_ID || state_ff == S_SUB || state_ff == S_LENH ||
                             state_ff == S_LENL || (state_ff == S_BODY && !body_last));
    assign nxt_cks = (state_ff == S_ID) ? rx_data_i : cks_ff ^ rx_data_i;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) cks_ff <= 8'h00;
        else if (cks_en) cks_ff <= nxt_cks;
    end

    // Packet verdict at the closing delimiter, length reject at the length low byte
    assign etx_take = take & (state_ff == S_ETX) & (rx_data_i == GCP_ETX);
    assign cks_ok   = cks_ff == body_ff[last_idx];
    assign mode_ok  = (len_ff == GCP_LEN_QUERY && body_ff[GCP_OFS_MODE] == GCP_MODE_QUERY) ||
                      (len_ff == GCP_LEN_SET && body_ff[GCP_OFS_MODE] == GCP_MODE_SET);
    assign good     = etx_take & cks_ok & mode_ok;
    assign good_set = good & (len_ff == GCP_LEN_SET);
    assign len_rej  = take & (state_ff == S_LENL) & !len_ok;
    assign bad      = (etx_take & !(cks_ok & mode_ok)) | len_rej;

    // Set fields, big-endian words
    assign band_w  = {body_ff[GCP_OFS_BAND], body_ff[GCP_OFS_BAND+1],
                      body_ff[GCP_OFS_BAND+2], body_ff[GCP_OFS_BAND+3]};
    assign elev_w  = {body_ff[GCP_OFS_ELEV], body_ff[GCP_OFS_ELEV+1],
                      body_ff[GCP_OFS_ELEV+2], body_ff[GCP_OFS_ELEV+3]};
    assign sig_w   = {body_ff[GCP_OFS_SIG], body_ff[GCP_OFS_SIG+1],
                      body_ff[GCP_OFS_SIG+2], body_ff[GCP_OFS_SIG+3]};
    assign dop_w   = {body_ff[GCP_OFS_DOP], body_ff[GCP_OFS_DOP+1],
                      body_ff[GCP_OFS_DOP+2], body_ff[GCP_OFS_DOP+3]};
    assign delay_w = {body_ff[GCP_OFS_DELAY], body_ff[GCP_OFS_DELAY+1],
                      body_ff[GCP_OFS_DELAY+2], body_ff[GCP_OFS_DELAY+3]};

    // Ignore sentinels; bytes 22 and 23 are never applied
    assign band_skip = band_w == GCP_BAND_IGNORE;
    assign elev_skip = elev_w[31:24] == GCP_BYTE_IGNORE;
    assign sig_skip  = sig_w[31:24] == GCP_BYTE_IGNORE;
    assign dop_skip  = dop_w == GCP_DOP_IGNORE;

    // Next settings, unsupported band bits dropped
    assign nxt_settings.band  = band_skip ? settings_ff.band : band_w & GCP_BAND_SUPP;
    assign nxt_settings.elev  = elev_skip ? settings_ff.elev : elev_w;
    assign nxt_settings.min_signal_strength_limit =
        sig_skip ? settings_ff.min_signal_strength_limit : sig_w;
    assign nxt_settings.max_dilution_limit = dop_skip ? settings_ff.max_dilution_limit : dop_w;
    assign nxt_settings.delay = delay_w;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) settings_ff <= {GCP_BAND_RST, GCP_ELEV_RST, GCP_SIG_RST, GCP_DOP_RST, GCP_DELAY_RST};
        else if (good_set) settings_ff <= nxt_settings;
    end

    assign settings_o = settings_ff;

    // Answer request, a new packet wins over the clear
    assign tx_start = pend_ff & !tx_busy;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) pend_ff <= 1'b0;
        else pend_ff <= good | (pend_ff & !tx_start);
    end

    // Packet counters
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            good_cnt_ff <= 8'h00;
            bad_cnt_ff  <= 8'h00;
        end else begin
            good_cnt_ff <= good_cnt_ff + {7'h00, good};
            bad_cnt_ff  <= bad_cnt_ff + {7'h00, bad};
        end
    end

    gcp_resp_tx u_resp_tx (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .start_i    (tx_start),
        .settings_i (settings_ff),
        .busy_o     (tx_busy),
        .tx_data_o  (tx_data_o),
        .tx_valid_o (tx_valid_o),
        .tx_ready_i (tx_ready_i)
    );

    // AHB-Lite decode, zero wait, always OKAY
    assign ahb_go  = hsel_i & htrans_i[1] & hready_i;
    assign ahb_ofs = haddr_i[7:0];
    assign rd_mux  = (ahb_ofs == GCP_REG_CTRL)  ? {31'h0000_0000, en_ff} :
                     (ahb_ofs == GCP_REG_STAT)  ? {8'h00, bad_cnt_ff, good_cnt_ff, 7'h00, tx_busy} :
                     (ahb_ofs == GCP_REG_BAND)  ? settings_ff.band :
                     (ahb_ofs == GCP_REG_ELEV)  ? settings_ff.elev :
                     (ahb_ofs == GCP_REG_SIG)   ? settings_ff.min_signal_strength_limit :
                     (ahb_ofs == GCP_REG_DOP)   ? settings_ff.max_dilution_limit :
                     (ahb_ofs == GCP_REG_DELAY) ? settings_ff.delay : 32'h0000_0000;

    // Address phase capture and read data
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= ahb_go & hwrite_i;
            wr_addr_ff <= ahb_go ? ahb_ofs : wr_addr_ff;
            rdata_ff   <= (ahb_go && !hwrite_i) ? rd_mux : rdata_ff;
        end
    end

    // Parser enable, written in the data phase
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) en_ff <= GCP_EN_RST;
        else if (wr_pend_ff && wr_addr_ff == GCP_REG_CTRL) en_ff <= hwdata_i[0];
    end

    assign hrdata_o    = rdata_ff;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // Checks on settings and verdicts
    band_supp_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (settings_ff.band & ~GCP_BAND_SUPP) == 32'h0000_0000)
        else $error("unsupported band bit enabled");
    band_keep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        good_set && band_skip |=> $stable(settings_ff.band))
        else $error("ignored band mask was applied");
    band_take_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        good_set && !band_skip |=> settings_ff.band == ($past(band_w) & GCP_BAND_SUPP))
        else $error("band mask not applied");
    elev_take_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        good_set && !elev_skip |=> settings_ff.elev == $past(elev_w))
        else $error("elevation not applied");
    sig_keep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        good_set && sig_skip |=> $stable(settings_ff.min_signal_strength_limit))
        else $error("ignored signal limit was applied");
    sig_take_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        good_set && !sig_skip |=> settings_ff.min_signal_strength_limit == $past(sig_w))
        else $error("signal limit not applied");
    dop_keep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        good_set && dop_skip |=> $stable(settings_ff.max_dilution_limit))
        else $error("ignored dilution limit was applied");
    bad_cks_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        etx_take && !cks_ok |=> $stable(good_cnt_ff) && $stable(settings_ff))
        else $error("packet with bad checksum accepted");
    len_rej_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        len_rej |=> state_ff == S_IDLE)
        else $error("bad length not rejected");
    resp_go_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        good |=> pend_ff ##[0:1000] tx_start)
        else $error("no answer started after valid packet");

    query_c: cover property (@(posedge clk_i) disable iff (!resetn_i) good && !good_set);
    set_c:   cover property (@(posedge clk_i) disable iff (!resetn_i) good_set && band_skip);
    bad_c:   cover property (@(posedge clk_i) disable iff (!resetn_i) etx_take && !cks_ok);
endmodule

//--- dv/gcp_host_model.sv
// Purpose: Host model, sends config packets and sinks answer bytes
// Assumes: One byte per rx_valid cycle; sink may stall every other cycle
// Notes:   Length and checksum worked out here from the body bytes
`timescale 1ns/10ps
module gcp_host_model (
    // Clock
    input  wire logic       clk_i,
    // Bytes to the device
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    // Bytes from the device
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o
);
    logic [7:0] got_q[$];
    logic       slow = 1'b0;
    initial begin
        rx_data_o  = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b1;
    end
    // Sink takes offered bytes, stalls every other cycle when slow
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) got_q.push_back(tx_data_i);
        tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
    end
    // Body is left aligned, n bytes: mode then payload
    task send_pkt(input logic [215:0] body, input int n, input logic bad);
        logic [7:0]  f[$];
        logic [15:0] len;
        logic [7:0]  cks;
        len = 16'(n + 1);
        f = {8'h91, 8'h01, len[15:8], len[7:0]};
        for (int i = 0; i < n; i++) f.push_back(body[215 - 8 * i -: 8]);
        cks = 8'h00;
        foreach (f[i]) cks ^= f[i];
        f.push_front(8'h10);
        f.push_back(cks ^ {7'h00, bad});
        f.push_back(8'h10);
        f.push_back(8'h03);
        foreach (f[i]) begin
            @(posedge clk_i);
            rx_data_o  <= f[i];
            rx_valid_o <= 1'b1;
        end
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o  <= 8'hFC;
    endtask
endmodule

//--- dv/testbench.sv
// Purpose: Self-checking bench for the config packet handler
// Assumes: Zero wait AHB-Lite slave, answer follows each good packet
// Notes:   Expected settings tracked in exp_s from the field rules
`timescale 1ns/10ps
module testbench;
    import gcp_pkg::*;
    logic          clk_i, resetn_i, hsel, hwrite, hready, hresp;
    logic [1:0]    htrans = 2'b00;
    logic [31:0]   haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [7:0]    rx_data, tx_data;
    logic          rx_valid, tx_valid, tx_ready;
    gcp_settings_t settings, exp_s;
    int            err_total = 0;
    int            comparisons = 0;
    initial hsel = 1'b0;
    initial hwrite = 1'b0;
    gcp_cfg_handler u_gcp_cfg_handler (.clk_i(clk_i), .resetn_i(resetn_i), .rx_data_i(rx_data),
        .rx_valid_i(rx_valid), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
        .settings_o(settings), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp));
    gcp_host_model u_gcp_host_model (.clk_i(clk_i), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
    // Clock, 25 ns period
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task chk(input string what, input logic [159:0] seen, input logic [159:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Single AHB-Lite word transfer
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_i); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0000_0000);
    endtask
    // Waits for a full answer and compares every byte
    task expect_answer(input gcp_settings_t s);
        logic [247:0] p;
        logic [7:0]   c;
        p = {8'h91, 8'h01, 16'h001C, 8'h02, s.band, s.elev, s.min_signal_strength_limit,
             s.max_dilution_limit, 8'h01, 8'h00, s.delay, 32'hFFFF_FFFF};
        c = 8'h00;
        for (int i = 0; i < 31; i++) c ^= p[247 - 8 * i -: 8];
        for (int n = 0; n < 400 && u_gcp_host_model.got_q.size() < 35; n++) @(posedge clk_i);
        chk("answer length", u_gcp_host_model.got_q.size(), 35);
        if (u_gcp_host_model.got_q.size() >= 35) begin
            chk("answer start", u_gcp_host_model.got_q[0], 8'h10);
            for (int i = 0; i < 31; i++)
                chk("answer byte", u_gcp_host_model.got_q[i + 1], p[247 - 8 * i -: 8]);
            chk("answer cks", u_gcp_host_model.got_q[32], c);
            chk("answer end", {u_gcp_host_model.got_q[33], u_gcp_host_model.got_q[34]}, 16'h1003);
        end
        u_gcp_host_model.got_q.delete();
    endtask
    task set_pkt(input logic [31:0] b, e, s, d, input logic [15:0] af, input logic [31:0] dl, input logic bad);
        u_gcp_host_model.send_pkt({8'h01, b, e, s, d, af, dl, 32'h0000_0000}, 27, bad);
    endtask
    task t_query;
        ahb(1'b0, 32'(GCP_REG_BAND), 32'h0);
        chk("band reg", rd, GCP_BAND_RST);
        ahb(1'b0, 32'h0000_0040, 32'h0);
        chk("unmapped", rd, 32'h0000_0000);
        u_gcp_host_model.send_pkt({8'h00, 208'h0}, 1, 1'b0);
        expect_answer(exp_s);
        $display("Test query done");
    endtask
    task t_set;
        u_gcp_host_model.slow = 1'b1;
        set_pkt(32'h0000_0003, 32'h42B4_0000, 32'h4214_0000, 32'h4040_0000, 16'h00FF, 32'h3380_0000, 1'b0);
        exp_s = '{32'h0000_0001, 32'h42B4_0000, 32'h4214_0000, 32'h4040_0000, 32'h3380_0000};
        expect_answer(exp_s);
        chk("settings band", settings.band, 32'h0000_0001);
        chk("settings dop", settings.max_dilution_limit, 32'h4040_0000);
        set_pkt(32'hFFFF_FFFF, 32'hFF00_0000, 32'hFF12_3456, 32'hBF80_0000, 16'hFF00, 32'h0000_0000, 1'b0);
        exp_s.delay = 32'h0000_0000;
        expect_answer(exp_s);
        chk("settings all", settings, exp_s);
        u_gcp_host_model.slow = 1'b0;
        $display("Test set done");
    endtask
    task t_reject;
        logic [31:0] st;
        ahb(1'b0, 32'(GCP_REG_STAT), 32'h0);
        st = rd;
        set_pkt(32'h0000_0010, 32'h0, 32'h0, 32'h0, 16'h0100, 32'h0, 1'b1);
        repeat (60) @(posedge clk_i);
        chk("no answer bad", u_gcp_host_model.got_q.size(), 0);
        chk("kept on bad", settings, exp_s);
        u_gcp_host_model.send_pkt({8'h00, 8'h00, 200'h0}, 2, 1'b0);
        repeat (60) @(posedge clk_i);
        chk("no answer len", u_gcp_host_model.got_q.size(), 0);
        chk("kept on len", settings, exp_s);
        ahb(1'b0, 32'(GCP_REG_STAT), 32'h0);
        chk("reject count", rd[23:16], st[23:16] + 8'h02);
        ahb(1'b1, 32'(GCP_REG_CTRL), 32'h0000_0000);
        u_gcp_host_model.send_pkt({8'h00, 208'h0}, 1, 1'b0);
        repeat (60) @(posedge clk_i);
        chk("no answer off", u_gcp_host_model.got_q.size(), 0);
        ahb(1'b1, 32'(GCP_REG_CTRL), 32'h0000_0001);
        u_gcp_host_model.send_pkt({8'h00, 208'h0}, 1, 1'b0);
        expect_answer(exp_s);
        $display("Test reject done");
    endtask
    task tally_and_finish;
        $display("Comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #(25 * 20000);
        err_total++;
        tally_and_finish();
    end
    initial begin
        exp_s = '{GCP_BAND_RST, GCP_ELEV_RST, GCP_SIG_RST, GCP_DOP_RST, GCP_DELAY_RST};
        resetn_i = 1'b0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_query();
        t_set();
        t_reject();
        tally_and_finish();
    end
endmodule
